// [core/plbw_map.vh]
// Register map and constants of the PLL bandwidth and programming controller
// Assumes byte addresses on a 32-bit APB, one register per aligned word
`ifndef PLBW_MAP_VH
`define PLBW_MAP_VH
`define PLBW_OFF_CTRL 12'h000
`define PLBW_OFF_BWC 12'h004
`define PLBW_OFF_PROG 12'h008
`define PLBW_OFF_BRK 12'h00c
// Loop control register bit positions
`define PLBW_CTL_IE 7
`define PLBW_CTL_FLAG 6
`define PLBW_CTL_ON 5
`define PLBW_CTL_BCS 4
// Bandwidth control register bit positions
`define PLBW_BWC_AUTO 7
`define PLBW_BWC_LOCK 6
`define PLBW_BWC_TRK 5
`define PLBW_BWC_XLD 4
// Break flag control register bit position
`define PLBW_BRK_BREAK_CLEAR_ENABLE 7
// Reset values
`define PLBW_RST_MUL 4'h6
`define PLBW_RST_VRS 4'h6
`define PLBW_RST_ON 1'b1
// Crystal check window: N times this many cycles
`define PLBW_XLD_CYC_PER_N 4
`endif

// [core/plbw_ctrl.v]
// PLL bandwidth and programming control with APB register access
// Assumes analog loop supplies lock/tracking status and crystal activity
// Functional notes
// - Auto bit selects auto bandwidth, reset clears
// - Lock reads live in auto, zero manual
// - Tracking bit: status auto, control manual
// - Manual tracking value kept during auto
// - Crystal check: write one, wait, read
// - Crystal loss only with VCO selected
// - Multiplier field, zero acts as one, reset six
// - Multiplier writes ignored while PLL on
// - Range field, locked while on, reset six
// - Range zero disables PLL, clears select
// - Auto mode: flag on lock change, gated irq
// - Manual mode: no irq, flag reads zero
// - VCO may be selected while unlocked
// - Generator keeps running in wait mode
// - Stop disables generator, outputs held low
// - Stop clears select, crystal drives base clock
// - Break clear enable: cleared bits stay cleared
// - Break without enable leaves flag untouched
// - Acquisition ends when status shows tracking
// - Control register read clears change flag
// - Select cannot be set while PLL off
// - Base clock held during source switch
// - Manual mode: irq enable ignores writes, reads zero
//
// The placing of the registers and register access over APB were chosen for this implementation.
`include "plbw_map.vh"
module plbw_ctrl #(
    parameter SWITCH_CYC = 6
)(
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire loop_lock_in,
    input wire loop_tracking_in,
    input wire crystal_active_in,
    input wire stop_req,
    input wire wait_mode,
    input wire break_state,
    output reg loop_enable,
    output reg loop_tracking_force,
    output reg [3:0] feedback_ratio,
    output reg [3:0] vco_range,
    output reg vco_select,
    output reg base_clock_hold,
    output reg crystal_clock_en,
    output reg base_clock_en,
    output reg clockgen_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Register state
    reg auto_bw;
    reg irq_en;
    reg chg_flag;
    reg loop_power_on;
    reg base_clock_select;
    reg trk_store;
    reg xld_flag;
    reg [5:0] xld_cnt;
    reg [3:0] fb_field;
    reg [3:0] vrs_field;
    reg break_clear_enable;
    reg [7:0] sw_cnt;
    reg lk_s1, lk_s2, lk_d;
    reg tk_s1, tk_s2;
    reg xa_s1, xa_s2;
    reg st_s1, st_s2;
    wire stop_now = st_s2;

    // Multiplier N with zero treated as one
    function [3:0] mul_n;
        input [3:0] f;
        begin
            mul_n = (f == 4'h0) ? 4'h1 : f;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctl = (paddr == `PLBW_OFF_CTRL);
    wire hit_bwc = (paddr == `PLBW_OFF_BWC);
    wire hit_prg = (paddr == `PLBW_OFF_PROG);
    wire hit_brk = (paddr == `PLBW_OFF_BRK);
    wire mapped = hit_ctl | hit_bwc | hit_prg | hit_brk;
    // Flag clear by access is blocked during break unless enabled
    wire flag_clr_ok = !break_state || break_clear_enable;
    wire lock_vis = auto_bw & lk_s2;
    wire trk_vis = auto_bw ? tk_s2 : trk_store;
    wire lock_edge = lk_s2 ^ lk_d;
    wire xld_vis = base_clock_select & xld_flag;

    // Read data mux
    reg [7:0] rd_byte;
    always @*
    begin
        rd_byte = 8'h00;
        case (paddr)
            `PLBW_OFF_CTRL: rd_byte = {auto_bw & irq_en, auto_bw & chg_flag, loop_power_on,
                base_clock_select, 4'hf};
            `PLBW_OFF_BWC: rd_byte = {auto_bw, lock_vis, trk_vis, xld_vis, 4'h0};
            `PLBW_OFF_PROG: rd_byte = {fb_field, vrs_field};
            `PLBW_OFF_BRK: rd_byte = {break_clear_enable, 7'h00};
            default: rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    always @(posedge clk)
    begin
        if (srst)
        begin
            {lk_s1, lk_s2, lk_d, tk_s1, tk_s2, xa_s1, xa_s2, st_s1, st_s2} <= 9'h000;
        end
        else
        begin
            lk_s1 <= loop_lock_in;
            lk_s2 <= lk_s1;
            lk_d <= lk_s2;
            tk_s1 <= loop_tracking_in;
            tk_s2 <= tk_s1;
            xa_s1 <= crystal_active_in;
            xa_s2 <= xa_s1;
            st_s1 <= stop_req;
            st_s2 <= st_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB response, one wait-free access phase
    always @(posedge clk)
    begin
        if (srst)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Transfer completes in the cycle pready is high
    wire done = acc && pready;

    ////////////////////////////////////////////////////////////////////////////
    // Control register and change flag
    always @(posedge clk)
    begin
        if (srst)
        begin
            irq_en <= 1'b0;
            chg_flag <= 1'b0;
            loop_power_on <= `PLBW_RST_ON;
            base_clock_select <= 1'b0;
            break_clear_enable <= 1'b0;
        end
        else
        begin
            if (done && wr && hit_brk)
                break_clear_enable <= pwdata[`PLBW_BRK_BREAK_CLEAR_ENABLE];
            // Set wins over read clear
            if (auto_bw && lock_edge)
                chg_flag <= 1'b1;
            else if (done && hit_ctl && flag_clr_ok)
                chg_flag <= 1'b0;
            // Range zero or stop forces the crystal; other control bits still take writes
            if (stop_now || vrs_field == 4'h0)
                base_clock_select <= 1'b0;
            else if (done && wr && hit_ctl && (!pwdata[`PLBW_CTL_BCS] || loop_power_on))
                base_clock_select <= pwdata[`PLBW_CTL_BCS];
            if (done && wr && hit_ctl)
            begin
                if (auto_bw)
                    irq_en <= pwdata[`PLBW_CTL_IE];
                // Power cannot drop while VCO selected
                if (pwdata[`PLBW_CTL_ON] || !base_clock_select)
                    loop_power_on <= pwdata[`PLBW_CTL_ON];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bandwidth register and crystal loss check
    always @(posedge clk)
    begin
        if (srst)
        begin
            auto_bw <= 1'b0;
            trk_store <= 1'b0;
            xld_flag <= 1'b0;
            xld_cnt <= 6'h00;
        end
        else
        begin
            if (done && wr && hit_bwc)
            begin
                auto_bw <= pwdata[`PLBW_BWC_AUTO];
                if (!auto_bw)
                    trk_store <= pwdata[`PLBW_BWC_TRK];
            end
            if (done && wr && hit_bwc && pwdata[`PLBW_BWC_XLD] && base_clock_select)
            begin
                xld_flag <= 1'b1;
                xld_cnt <= {mul_n(fb_field), 2'b00};
            end
            else if (!base_clock_select)
            begin
                xld_flag <= 1'b0;
                xld_cnt <= 6'h00;
            end
            else if (xa_s2)
                xld_flag <= 1'b0;
            else if (xld_cnt != 6'h00)
                xld_cnt <= xld_cnt - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Programming register, protected while PLL on
    always @(posedge clk)
    begin
        if (srst)
        begin
            fb_field <= `PLBW_RST_MUL;
            vrs_field <= `PLBW_RST_VRS;
        end
        else if (done && wr && hit_prg && !loop_power_on)
        begin
            fb_field <= pwdata[7:4];
            vrs_field <= pwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source switch hold counter
    always @(posedge clk)
    begin
        if (srst)
            sw_cnt <= 8'h00;
        else if (vco_select != (base_clock_select && vrs_field != 4'h0))
            sw_cnt <= SWITCH_CYC[7:0];
        else if (sw_cnt != 8'h00)
            sw_cnt <= sw_cnt - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs to the analog loop and clock tree
    always @(posedge clk)
    begin
        if (srst)
        begin
            loop_enable <= 1'b0;
            loop_tracking_force <= 1'b0;
            feedback_ratio <= `PLBW_RST_MUL;
            vco_range <= `PLBW_RST_VRS;
            vco_select <= 1'b0;
            base_clock_hold <= 1'b0;
            crystal_clock_en <= 1'b0;
            base_clock_en <= 1'b0;
            clockgen_irq <= 1'b0;
        end
        else
        begin
            // Wait mode does not gate anything here
            loop_enable <= loop_power_on && vrs_field != 4'h0 && !stop_now;
            loop_tracking_force <= auto_bw ? 1'b0 : trk_store;
            feedback_ratio <= mul_n(fb_field);
            vco_range <= vrs_field;
            vco_select <= base_clock_select && vrs_field != 4'h0;
            base_clock_hold <= (vco_select != (base_clock_select && vrs_field != 4'h0))
                || (sw_cnt > 8'h01);
            crystal_clock_en <= !stop_now;
            base_clock_en <= !stop_now;
            clockgen_irq <= !stop_now && auto_bw && irq_en && chg_flag;
        end
    end
endmodule // plbw_ctrl

// [tb/plbw_ctrl_props.sv]
// Assertions on the PLL control block ports
// Assumes one clock domain and the bind below
module plbw_ctrl_props (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire stop_req,
    input wire loop_enable,
    input wire [3:0] feedback_ratio,
    input wire [3:0] vco_range,
    input wire vco_select,
    input wire base_clock_hold,
    input wire crystal_clock_en,
    input wire base_clock_en,
    input wire clockgen_irq
);
    // Shared clock and reset
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("late or long answer");
    chk_ratio_nonzero: assert property (feedback_ratio != 4'h0)
        else $error("ratio zero");
    chk_fields_frozen: assert property (loop_enable |=> $stable(feedback_ratio) && $stable(vco_range))
        else $error("field moved while on");
    chk_range_off: assert property (vco_range == 4'h0 |=> !loop_enable && !vco_select)
        else $error("range zero left loop on");
    chk_select_guard: assert property ($rose(vco_select) |-> $past(loop_enable))
        else $error("select rose while off");
    chk_switch_hold: assert property ($changed(vco_select) && !stop_req |-> ##[0:2] base_clock_hold ##[1:9] !base_clock_hold)
        else $error("switch hold missing");
    chk_stop_low: assert property (stop_req [*4] |=> !crystal_clock_en && !base_clock_en && !clockgen_irq)
        else $error("outputs up in stop");
    chk_stop_select: assert property (stop_req [*4] |=> !vco_select && !loop_enable)
        else $error("select kept in stop");
    // Main scenarios reached
    cover property ($rose(clockgen_irq));
    cover property ($fell(base_clock_en));
    cover property ($rose(vco_select));
endmodule // plbw_ctrl_props
bind plbw_ctrl plbw_ctrl_props plbw_ctrl_props_inst (.clk, .srst, .psel, .penable, .pready, .stop_req,
    .loop_enable, .feedback_ratio, .vco_range, .vco_select, .base_clock_hold, .crystal_clock_en,
    .base_clock_en, .clockgen_irq);

// [tb/plbw_loop_model.sv]
// Analog loop model: locks a fixed time after enable
// Assumes lock_ok from the bench can break the lock
module plbw_loop_model #(
    parameter int LOCK_CYC = 8
)(
    input wire logic clk,
    input wire logic loop_enable,
    input wire logic lock_ok,
    output logic lock,
    output logic tracking
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Settling count restarts while off
    always @(posedge clk)
        cnt <= loop_enable ? (cnt < LOCK_CYC ? cnt + 1 : cnt) : 0;
    // Tracking entered together with lock
    assign lock = lock_ok && cnt == LOCK_CYC;
    assign tracking = lock;
endmodule // plbw_loop_model

// [tb/plbw_ctrl_tb.sv]
// Bench of the PLL control block over APB
// Assumes the loop model and bound checker
module plbw_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d;} plbw_row_t;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, lock, trk, lock_ok = 1, xtal = 1, stop = 0, brk = 0;
    logic loop_enable, vsel, xen, ben, irq;
    logic [3:0] ratio, rng;
    logic hold, force_trk, wt = 0;
    int failures = 0, n_compared = 0, cyc = 0;
    // Writes carry data, reads the expected word
    plbw_row_t rows[22] = '{
        '{0, 12'h000, 32'h2f},
        '{0, 12'h004, 32'h00},
        '{0, 12'h008, 32'h66},
        '{0, 12'h00c, 32'h00},
        '{1, 12'h008, 32'h31},
        '{0, 12'h008, 32'h66},
        '{1, 12'h000, 32'h00},
        '{0, 12'h000, 32'h0f},
        '{1, 12'h008, 32'h0a},
        '{0, 12'h008, 32'h0a},
        '{1, 12'h000, 32'h10},
        '{0, 12'h000, 32'h0f},
        '{1, 12'h000, 32'h80},
        '{0, 12'h000, 32'h0f},
        '{1, 12'h004, 32'h20},
        '{0, 12'h004, 32'h20},
        '{1, 12'h004, 32'ha0},
        '{0, 12'h004, 32'h80},
        '{1, 12'h004, 32'h20},
        '{0, 12'h004, 32'h20},
        '{1, 12'h004, 32'h00},
        '{0, 12'h010, 32'h00}
    };
    plbw_ctrl plbw_ctrl_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .loop_lock_in(lock), .loop_tracking_in(trk), .crystal_active_in(xtal), .stop_req(stop),
        .wait_mode(wt), .break_state(brk), .loop_enable, .loop_tracking_force(force_trk), .feedback_ratio(ratio),
        .vco_range(rng), .vco_select(vsel), .base_clock_hold(hold), .crystal_clock_en(xen), .base_clock_en(ben),
        .clockgen_irq(irq));
    plbw_loop_model plbw_loop_model_inst (.clk, .loop_enable, .lock_ok, .lock, .tracking(trk));
    // Clock and hang limit
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            results;
        end
    end
    ////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task results;
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 0;
        foreach (rows[i])
            if (rows[i].w) apb(1, rows[i].a, rows[i].d);
            else rdc(rows[i].a, rows[i].d);
        chk(32'(err), 1);
        chk(32'(ratio), 1);
        apb(1, 12'h008, 32'h60);
        apb(1, 12'h000, 32'h20);
        apb(1, 12'h000, 32'h30);
        chk(32'({loop_enable, vsel}), 0);
        apb(1, 12'h000, 32'h00);
        apb(1, 12'h008, 32'h22);
        apb(1, 12'h000, 32'h20);
        apb(1, 12'h004, 32'h80);
        repeat (16) @(posedge clk);
        chk(32'(rng), 2);
        rdc(12'h000, 32'h6f);
        rdc(12'h000, 32'h2f);
        apb(1, 12'h000, 32'ha0);
        lock_ok <= 0;
        repeat (6) @(posedge clk);
        chk(32'(irq), 1);
        rdc(12'h004, 32'h80);
        rdc(12'h000, 32'hef);
        repeat (2) @(posedge clk);
        chk(32'(irq), 0);
        lock_ok <= 1;
        repeat (6) @(posedge clk);
        brk <= 1;
        rdc(12'h000, 32'hef);
        rdc(12'h000, 32'hef);
        apb(1, 12'h00c, 32'h80);
        rdc(12'h000, 32'hef);
        brk <= 0;
        rdc(12'h000, 32'haf);
        apb(1, 12'h000, 32'h30);
        repeat (2) @(posedge clk);
        chk(32'(vsel), 1);
        chk(32'(hold), 1);
        xtal <= 0;
        apb(1, 12'h004, 32'h90);
        repeat (12) @(posedge clk);
        rdc(12'h004, 32'hf0);
        xtal <= 1;
        repeat (6) @(posedge clk);
        rdc(12'h004, 32'he0);
        stop <= 1;
        repeat (8) @(posedge clk);
        chk(32'({ben, xen, irq, vsel}), 0);
        stop <= 0;
        repeat (8) @(posedge clk);
        chk(32'({vsel, ben}), 1);
        apb(1, 12'h004, 32'h20);
        apb(1, 12'h004, 32'h20);
        repeat (2) @(posedge clk);
        chk(32'(force_trk), 1);
        wt <= 1;
        repeat (4) @(posedge clk);
        chk(32'({xen, ben}), 3);
        results;
    end
endmodule // plbw_ctrl_tb
